// ===== src/rxq_pkg.sv
// Constants for the receive acceptance and event queue register bank
package rxq_pkg;
	// Register window offsets (byte addresses)
	localparam logic [11:0] OFF_ISQ = 12'h120;
	localparam logic [11:0] OFF_ISQ_IO = 12'h008;
	localparam logic [11:0] OFF_RX_EVT = 12'h124;
	localparam logic [11:0] OFF_TX_EVT = 12'h128;
	localparam logic [11:0] OFF_BUF_EVT = 12'h12c;
	localparam logic [11:0] OFF_MISS = 12'h130;
	localparam logic [11:0] OFF_COL = 12'h132;
	localparam logic [11:0] OFF_TX_CMD = 12'h108;
	localparam logic [11:0] OFF_LINE_ST = 12'h134;
	localparam logic [11:0] OFF_SELF_ST = 12'h136;
	localparam logic [11:0] OFF_BUS_ST = 12'h138;
	// Read/write configuration and control registers, by slot
	localparam int NUM_CFG = 8;
	localparam logic [11:0] CFG_OFF [NUM_CFG] = '{12'h102, 12'h104, 12'h106, 12'h10a,
		12'h112, 12'h114, 12'h116, 12'h118};
	localparam logic [5:0] CFG_NUM [NUM_CFG] = '{6'h03, 6'h05, 6'h07, 6'h0b,
		6'h13, 6'h15, 6'h17, 6'h19};
	localparam int SLOT_RX_CFG = 0;
	localparam int SLOT_RX_CTL = 1;
	localparam int SLOT_TX_CFG = 2;
	localparam int SLOT_BUF_CFG = 3;
	localparam int SLOT_BUS_CTL = 6;
	localparam logic [9:0] CFG_RST = 10'h000;
	// Register numbers in the low six bits
	localparam logic [5:0] NUM_RX_EVT = 6'h04;
	localparam logic [5:0] NUM_TX_EVT = 6'h08;
	localparam logic [5:0] NUM_BUF_EVT = 6'h0c;
	localparam logic [5:0] NUM_MISS = 6'h10;
	localparam logic [5:0] NUM_COL = 6'h12;
	localparam logic [5:0] NUM_TX_CMD = 6'h09;
	localparam logic [5:0] NUM_LINE_ST = 6'h14;
	localparam logic [5:0] NUM_SELF_ST = 6'h16;
	localparam logic [5:0] NUM_BUS_ST = 6'h18;
	// Word layout: number in bits 5-0, contents in bits F-6
	localparam int NUM_LSB = 0;
	localparam int CONT_LSB = 6;
	localparam logic [15:0] ISQ_RST = 16'h0000;
	localparam logic [9:0] CONT_RST = 10'h000;
	// Upper-field bit positions (register bit minus six)
	localparam int B_OVERSIZE = 8;
	localparam int B_UNDERSIZE = 7;
	localparam int B_BAD_CHECK = 6;
	localparam int B_ALL_STATIONS = 5;
	localparam int B_OWN_ADDR = 4;
	localparam int B_GROUP = 3;
	localparam int B_HASHED = 3;
	localparam int B_GOOD = 2;
	localparam int B_EVERYTHING = 1;
	localparam int B_DRIBBLE = 1;
	localparam int B_OWN_HASH = 0;
	localparam int B_SWINT = 0;
	localparam int B_MISS_OVF_EN = 7;
	localparam int B_COL_OVF_EN = 6;
	localparam int B_IRQ_ENABLE = 9;
	localparam logic [9:0] BUF_IRQ_MASK = 10'h23e;
	localparam logic [9:0] CNT_OVF_AT = 10'h1ff;
	localparam int NUM_EVT_SRC = 3;
endpackage : rxq_pkg

// ===== src/rxq_src_if.sv
// Signals between the bank and one event source register
`timescale 1ns/10ps
interface rxq_src_if;
	logic [9:0] set_bits; // Event bits to set
	logic hit; // Enabled event occurred
	logic clr; // Host read clears the source
	logic [9:0] contents; // Current event bits
	logic pending; // Waiting in the status queue
	modport ctl (output set_bits, output hit, output clr, input contents, input pending);
	modport src (input set_bits, input hit, input clr, output contents, output pending);
endinterface : rxq_src_if

// ===== src/rxq_src.sv
// One read-to-clear event register with its queue pending flag
`timescale 1ns/10ps
module rxq_src (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	rxq_src_if.src sif // Set, clear and contents
);
	logic [9:0] cont_ff; // Event bits
	logic [9:0] nxt_cont; // Next event bits
	logic pend_ff; // Queue pending
	logic nxt_pend; // Next queue pending

	// Set wins over a clearing read in the same cycle
	always_comb begin
		nxt_cont = (sif.clr ? rxq_pkg::CONT_RST : cont_ff) | sif.set_bits; // RULE12
		nxt_pend = (sif.clr ? 1'b0 : pend_ff) | sif.hit; // RULE13
	end

	// Register the source
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cont_ff <= rxq_pkg::CONT_RST;
			pend_ff <= 1'b0;
		end else begin
			cont_ff <= nxt_cont;
			pend_ff <= nxt_pend;
		end
	end

	assign sif.contents = cont_ff;
	assign sif.pending = pend_ff;

	// A clearing read with no new event leaves the register empty
	AST_SRC_CLEAR_EMPTIES: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE13
		sif.clr && (sif.set_bits == 10'h000) && !sif.hit |=> (cont_ff == 10'h000) && !pend_ff)
		else $error("Source not cleared by read");
endmodule : rxq_src

// ===== src/rxq_regs.sv
// Receive acceptance controls, event registers and interrupt status queue
// Summary of operation
// RULE1: Nine acceptance bits held in receive control
// RULE2: Kept frame goes to buffer or DMA
// RULE3: Acceptance and interrupt enable act independently
// RULE4: Enabled, unaccepted class interrupts, discards, length zero
// RULE5: Five bits filter by destination address
// RULE6: Queue word: number low six, contents above
// RULE7: Enabled event sets bits, queues, raises interrupt
// RULE8: Queue sources: receive, transmit, buffer, two counters
// RULE9: Queue readable at 120h and I/O 0008h
// RULE10: Queue reads zero after reset
// RULE11: Queue is read-only in both modes
// RULE12: Event bits set regardless of interrupt enable
// RULE13: Reading an event register clears it
// RULE14: Empty queue reads zero, interrupt released
// RULE15: Host rereads queue until zero word
`timescale 1ns/10ps
module rxq_regs (
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic host_rd, // Read strobe, one cycle
	input wire logic host_wr, // Write strobe, one cycle
	input wire logic host_io, // Access through the I/O window
	input wire logic [11:0] host_addr, // Byte offset in the window
	input wire logic [15:0] host_wdata, // Write data
	output logic [15:0] host_rdata_ff, // Read data
	output logic host_rvalid_ff, // Read data valid pulse
	input wire logic rx_frame_done, // Frame end pulse from receiver
	input wire logic rx_oversize, // Frame too long
	input wire logic rx_undersize, // Frame too short
	input wire logic rx_bad_check, // Checksum failed
	input wire logic rx_dest_all, // Broadcast destination
	input wire logic rx_dest_own, // Own individual address
	input wire logic rx_dest_group, // Multicast destination
	input wire logic rx_dest_hash, // Hash filter match
	input wire logic rx_dribble, // Dribble bits seen
	input wire logic rx_dma_sel, // Receive path uses DMA
	input wire logic [9:0] tx_event_set, // Transmit event pulses, bits F-6
	input wire logic [9:0] buf_event_set, // Buffer event pulses, bits F-6
	input wire logic miss_inc, // Missed frame pulse
	input wire logic col_inc, // Collision pulse
	output logic irq_ff, // Interrupt request, high
	output logic rx_to_buffer_ff, // Frame kept in on-chip buffer
	output logic rx_to_dma_ff, // Frame kept through DMA
	output logic rx_len_zero_ff // Frame discarded, length zero
);
	logic [9:0] cfg_ff [rxq_pkg::NUM_CFG]; // Upper fields of config registers
	logic [9:0] nxt_cfg [rxq_pkg::NUM_CFG]; // Next config fields
	logic [9:0] miss_cnt_ff; // Missed frame counter
	logic [9:0] nxt_miss_cnt; // Next missed frame count
	logic [9:0] col_cnt_ff; // Collision counter
	logic [9:0] nxt_col_cnt; // Next collision count
	logic miss_pend_ff; // Missed counter overflow queued
	logic nxt_miss_pend; // Next missed overflow flag
	logic col_pend_ff; // Collision counter overflow queued
	logic nxt_col_pend; // Next collision overflow flag
	logic [15:0] nxt_rdata; // Next read data
	logic nxt_irq; // Next interrupt level
	logic nxt_to_buf; // Next buffer keep
	logic nxt_to_dma; // Next DMA keep
	logic nxt_len_zero; // Next discard flag
	logic [rxq_pkg::NUM_EVT_SRC-1:0] evt_clr; // Clear per event source
	logic [rxq_pkg::NUM_EVT_SRC-1:0] evt_pend; // Pending per event source
	logic [9:0] evt_cont [rxq_pkg::NUM_EVT_SRC]; // Contents per event source
	logic [9:0] evt_set [rxq_pkg::NUM_EVT_SRC]; // Set bits per event source
	logic [rxq_pkg::NUM_EVT_SRC-1:0] evt_hit; // Enabled hit per event source
	logic miss_clr; // Read clears missed counter
	logic col_clr; // Read clears collision counter
	logic isq_hit; // Access addresses the queue
	logic rx_good; // Frame had no error
	logic addr_ok; // Destination passes the filter
	logic class_ok; // Every class the frame shows, good included, allowed
	logic rx_keep; // Frame is kept
	logic swint; // Software interrupt request
	logic [9:0] rx_ctl; // Receive acceptance bits
	logic [9:0] rx_cfg; // Receive interrupt enables
	logic queue_empty; // No source waiting in the queue

	assign rx_ctl = cfg_ff[rxq_pkg::SLOT_RX_CTL]; // RULE1
	assign rx_cfg = cfg_ff[rxq_pkg::SLOT_RX_CFG];
	assign rx_good = !rx_oversize && !rx_undersize && !rx_bad_check;
	assign queue_empty = !(|evt_pend) && !miss_pend_ff && !col_pend_ff; // RULE14
	assign isq_hit = host_io ? (host_addr == rxq_pkg::OFF_ISQ_IO) : // RULE9
		(host_addr == rxq_pkg::OFF_ISQ);
	assign swint = host_wr && !host_io && (host_addr == rxq_pkg::CFG_OFF[rxq_pkg::SLOT_BUF_CFG])
		&& (host_wdata[5:0] == rxq_pkg::CFG_NUM[rxq_pkg::SLOT_BUF_CFG])
		&& host_wdata[rxq_pkg::CONT_LSB + rxq_pkg::B_SWINT];

	// Acceptance decision, separate from interrupt enables
	always_comb begin
		addr_ok = rx_ctl[rxq_pkg::B_EVERYTHING] // RULE5
			|| (rx_dest_all && rx_ctl[rxq_pkg::B_ALL_STATIONS])
			|| (rx_dest_own && rx_ctl[rxq_pkg::B_OWN_ADDR])
			|| (rx_dest_group && rx_ctl[rxq_pkg::B_GROUP])
			|| (rx_dest_hash && rx_ctl[rxq_pkg::B_OWN_HASH]);
		class_ok = (!rx_oversize || rx_ctl[rxq_pkg::B_OVERSIZE]) // RULE3
			&& (!rx_undersize || rx_ctl[rxq_pkg::B_UNDERSIZE])
			&& (!rx_bad_check || rx_ctl[rxq_pkg::B_BAD_CHECK])
			&& (!rx_good || rx_ctl[rxq_pkg::B_GOOD]);
		rx_keep = rx_frame_done && addr_ok && class_ok;
		nxt_to_buf = rx_keep && !rx_dma_sel; // RULE2
		nxt_to_dma = rx_keep && rx_dma_sel;
		nxt_len_zero = rx_frame_done && !rx_keep; // RULE4
	end

	// Event bits and enabled hits for the three event sources
	always_comb begin
		evt_set[0] = 10'h000;
		if (rx_frame_done) begin
			evt_set[0][rxq_pkg::B_OVERSIZE] = rx_oversize; // RULE12
			evt_set[0][rxq_pkg::B_UNDERSIZE] = rx_undersize;
			evt_set[0][rxq_pkg::B_BAD_CHECK] = rx_bad_check;
			evt_set[0][rxq_pkg::B_ALL_STATIONS] = rx_dest_all;
			evt_set[0][rxq_pkg::B_OWN_ADDR] = rx_dest_own;
			evt_set[0][rxq_pkg::B_HASHED] = rx_dest_hash;
			evt_set[0][rxq_pkg::B_GOOD] = rx_good;
			evt_set[0][rxq_pkg::B_DRIBBLE] = rx_dribble;
			evt_set[0][rxq_pkg::B_OWN_HASH] = rx_good && rx_dest_hash
				&& rx_ctl[rxq_pkg::B_OWN_HASH];
		end
		evt_hit[0] = rx_frame_done && ( // RULE4
			(rx_oversize && rx_cfg[rxq_pkg::B_OVERSIZE])
			|| (rx_undersize && rx_cfg[rxq_pkg::B_UNDERSIZE])
			|| (rx_bad_check && rx_cfg[rxq_pkg::B_BAD_CHECK])
			|| (rx_good && rx_cfg[rxq_pkg::B_GOOD]));
		evt_set[1] = tx_event_set;
		evt_hit[1] = |(tx_event_set & cfg_ff[rxq_pkg::SLOT_TX_CFG]);
		evt_set[2] = buf_event_set;
		evt_set[2][rxq_pkg::B_SWINT] = buf_event_set[rxq_pkg::B_SWINT] || swint;
		evt_hit[2] = |(buf_event_set & cfg_ff[rxq_pkg::SLOT_BUF_CFG]
			& rxq_pkg::BUF_IRQ_MASK) || swint;
	end

	// One event source register per receive, transmit and buffer
	generate
		for (genvar gi = 0; gi < rxq_pkg::NUM_EVT_SRC; gi++) begin : g_src
			rxq_src_if sif ();
			assign sif.set_bits = evt_set[gi];
			assign sif.hit = evt_hit[gi]; // RULE7
			assign sif.clr = evt_clr[gi];
			assign evt_cont[gi] = sif.contents;
			assign evt_pend[gi] = sif.pending;
			rxq_src u_src (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.sif(sif.src)
			);
		end
	endgenerate

	// Host read: queue selection, clears and read data
	always_comb begin
		evt_clr = '0;
		miss_clr = 1'b0;
		col_clr = 1'b0;
		nxt_rdata = 16'h0000;
		if (host_rd && isq_hit) begin
			// Fixed priority among pending sources; empty queue reads zero
			if (evt_pend[0]) begin // RULE8
				nxt_rdata = {evt_cont[0], rxq_pkg::NUM_RX_EVT}; // RULE6
				evt_clr[0] = 1'b1;
			end else if (evt_pend[1]) begin
				nxt_rdata = {evt_cont[1], rxq_pkg::NUM_TX_EVT};
				evt_clr[1] = 1'b1;
			end else if (evt_pend[2]) begin
				nxt_rdata = {evt_cont[2], rxq_pkg::NUM_BUF_EVT};
				evt_clr[2] = 1'b1;
			end else if (miss_pend_ff) begin
				nxt_rdata = {miss_cnt_ff, rxq_pkg::NUM_MISS};
				miss_clr = 1'b1;
			end else if (col_pend_ff) begin
				nxt_rdata = {col_cnt_ff, rxq_pkg::NUM_COL};
				col_clr = 1'b1;
			end else begin
				nxt_rdata = rxq_pkg::ISQ_RST; // RULE14
			end
		end else if (host_rd && !host_io) begin
			// Direct reads of the register window
			unique case (host_addr)
				rxq_pkg::OFF_RX_EVT: begin
					nxt_rdata = {evt_cont[0], rxq_pkg::NUM_RX_EVT};
					evt_clr[0] = 1'b1; // RULE13
				end
				rxq_pkg::OFF_TX_EVT: begin
					nxt_rdata = {evt_cont[1], rxq_pkg::NUM_TX_EVT};
					evt_clr[1] = 1'b1;
				end
				rxq_pkg::OFF_BUF_EVT: begin
					nxt_rdata = {evt_cont[2], rxq_pkg::NUM_BUF_EVT};
					evt_clr[2] = 1'b1;
				end
				rxq_pkg::OFF_MISS: begin
					nxt_rdata = {miss_cnt_ff, rxq_pkg::NUM_MISS};
					miss_clr = 1'b1;
				end
				rxq_pkg::OFF_COL: begin
					nxt_rdata = {col_cnt_ff, rxq_pkg::NUM_COL};
					col_clr = 1'b1;
				end
				rxq_pkg::OFF_TX_CMD: nxt_rdata = {10'h000, rxq_pkg::NUM_TX_CMD};
				rxq_pkg::OFF_LINE_ST: nxt_rdata = {10'h000, rxq_pkg::NUM_LINE_ST};
				rxq_pkg::OFF_SELF_ST: nxt_rdata = {10'h000, rxq_pkg::NUM_SELF_ST};
				rxq_pkg::OFF_BUS_ST: nxt_rdata = {10'h000, rxq_pkg::NUM_BUS_ST};
				default: begin
					for (int i = 0; i < rxq_pkg::NUM_CFG; i++) begin
						if (host_addr == rxq_pkg::CFG_OFF[i]) begin
							nxt_rdata = {cfg_ff[i], rxq_pkg::CFG_NUM[i]};
						end
					end
				end
			endcase
		end
	end

	// Config writes need the matching number in the low bits; queue ignores writes
	always_comb begin
		for (int i = 0; i < rxq_pkg::NUM_CFG; i++) begin
			nxt_cfg[i] = cfg_ff[i];
			if (host_wr && !host_io && (host_addr == rxq_pkg::CFG_OFF[i])
				&& (host_wdata[5:0] == rxq_pkg::CFG_NUM[i])) begin // RULE11
				nxt_cfg[i] = host_wdata[15:6];
			end
		end
		// Software interrupt bit acts once and reads back clear
		nxt_cfg[rxq_pkg::SLOT_BUF_CFG][rxq_pkg::B_SWINT] = 1'b0;
	end

	// Counters with overflow reports; a count wins over a clearing read
	always_comb begin
		nxt_miss_cnt = (miss_clr ? 10'h000 : miss_cnt_ff) + {9'h000, miss_inc};
		nxt_col_cnt = (col_clr ? 10'h000 : col_cnt_ff) + {9'h000, col_inc};
		nxt_miss_pend = (miss_clr ? 1'b0 : miss_pend_ff) || (miss_inc && !miss_clr
			&& (miss_cnt_ff == rxq_pkg::CNT_OVF_AT)
			&& cfg_ff[rxq_pkg::SLOT_BUF_CFG][rxq_pkg::B_MISS_OVF_EN]); // RULE8
		nxt_col_pend = (col_clr ? 1'b0 : col_pend_ff) || (col_inc && !col_clr
			&& (col_cnt_ff == rxq_pkg::CNT_OVF_AT)
			&& cfg_ff[rxq_pkg::SLOT_BUF_CFG][rxq_pkg::B_COL_OVF_EN]);
	end

	// Interrupt pin follows any queued source, gated by the enable bit
	always_comb begin
		nxt_irq = cfg_ff[rxq_pkg::SLOT_BUS_CTL][rxq_pkg::B_IRQ_ENABLE] // RULE7
			&& ((|evt_pend) || miss_pend_ff || col_pend_ff); // RULE14
	end

	// Register all state
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < rxq_pkg::NUM_CFG; i++) begin
				cfg_ff[i] <= rxq_pkg::CFG_RST;
			end
			miss_cnt_ff <= rxq_pkg::CONT_RST;
			col_cnt_ff <= rxq_pkg::CONT_RST;
			miss_pend_ff <= 1'b0;
			col_pend_ff <= 1'b0;
			host_rdata_ff <= rxq_pkg::ISQ_RST; // RULE10
			host_rvalid_ff <= 1'b0;
			irq_ff <= 1'b0;
			rx_to_buffer_ff <= 1'b0;
			rx_to_dma_ff <= 1'b0;
			rx_len_zero_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			miss_cnt_ff <= nxt_miss_cnt;
			col_cnt_ff <= nxt_col_cnt;
			miss_pend_ff <= nxt_miss_pend;
			col_pend_ff <= nxt_col_pend;
			host_rdata_ff <= nxt_rdata;
			host_rvalid_ff <= host_rd;
			irq_ff <= nxt_irq;
			rx_to_buffer_ff <= nxt_to_buf;
			rx_to_dma_ff <= nxt_to_dma;
			rx_len_zero_ff <= nxt_len_zero;
		end
	end

	// Checks
	sequence seq_isq_read;
		host_rd && isq_hit;
	endsequence
	sequence seq_queue_empty;
		queue_empty;
	endsequence

	AST_EMPTY_READS_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
		seq_isq_read and seq_queue_empty |=> host_rvalid_ff && (host_rdata_ff == 16'h0000))
		else $error("Empty queue read not zero");
	AST_QUEUE_NUMBER: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
		seq_isq_read and !queue_empty |=> host_rdata_ff[5:0] inside
		{6'h04, 6'h08, 6'h0c, 6'h10, 6'h12})
		else $error("Queue word carries wrong number");
	AST_RX_FIRST: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
		seq_isq_read and evt_pend[0] |=> (host_rdata_ff == {$past(evt_cont[0]), 6'h04}))
		else $error("Receive source word mismatch");
	AST_IRQ_RAISE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
		evt_hit[0] && cfg_ff[6][9] && !host_wr |=> ##1 irq_ff)
		else $error("Interrupt not raised");
	AST_IRQ_RELEASE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
		seq_queue_empty |=> !irq_ff)
		else $error("Interrupt held with empty queue");
	AST_SET_REGARDLESS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE12
		rx_frame_done && rx_bad_check |=> evt_cont[0][6])
		else $error("Bad check bit not set");
	AST_DISCARD_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
		rx_frame_done && rx_oversize && !rx_ctl[8] && rx_cfg[8]
		|=> rx_len_zero_ff && !rx_to_buffer_ff && !rx_to_dma_ff && evt_pend[0])
		else $error("Unaccepted oversize not discarded or not queued");
	AST_PROMISC_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
		rx_frame_done && rx_good && rx_ctl[1] && rx_ctl[2] |=> (rx_to_buffer_ff || rx_to_dma_ff))
		else $error("Promiscuous good frame not kept");
	AST_DMA_PATH: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
		rx_keep && rx_dma_sel |=> rx_to_dma_ff && !rx_to_buffer_ff)
		else $error("Kept frame on wrong path");
	AST_RESET_ZERO: assert property (@(posedge sys_clk) // RULE10
		$past(sys_rst) && !sys_rst |-> (host_rdata_ff == 16'h0000) && !irq_ff && queue_empty)
		else $error("Queue not zero after reset");
endmodule : rxq_regs

// ===== verif/rxq_host.sv
// Host model driving the register window strobes of the bank
`timescale 1ns/10ps
module rxq_host (
	input wire logic sys_clk, // System clock
	output logic host_rd, // Read strobe
	output logic host_wr, // Write strobe
	output logic host_io, // I/O window select
	output logic [11:0] host_addr, // Byte offset
	output logic [15:0] host_wdata, // Write data
	input wire logic [15:0] host_rdata_ff, // Read data
	input wire logic host_rvalid_ff // Read data valid
);
	int n_bad_valid; // Reads answered without valid
	// Idle bus at time zero
	initial begin
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_io = 1'b0;
		host_addr = 12'h000;
		host_wdata = 16'h0000;
		n_bad_valid = 0;
	end
	// One write, strobe high for a single cycle
	task reg_write(input logic io, input logic [11:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		host_io = io;
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge sys_clk);
		host_wr = 1'b0;
		host_addr = ~a; // Released lines do not keep their value
		host_wdata = ~d;
	endtask : reg_write
	// One read, data taken with the valid pulse
	task reg_read(input logic io, input logic [11:0] a, output logic [15:0] d);
		@(negedge sys_clk);
		host_io = io;
		host_addr = a;
		host_rd = 1'b1;
		@(negedge sys_clk);
		host_rd = 1'b0;
		host_addr = ~a;
		if (host_rvalid_ff !== 1'b1) begin
			n_bad_valid++;
		end
		d = host_rdata_ff;
	endtask : reg_read
	// Service loop: reread the queue until a zero word or eight words
	task drain(input logic io, output logic [15:0] q [$]);
		logic [15:0] w;
		q = {};
		do begin
			reg_read(io, io ? 12'h008 : 12'h120, w);
			q.push_back(w);
		end while (w !== 16'h0000 && q.size() < 8);
	endtask : drain
endmodule : rxq_host

// ===== verif/testbench.sv
// Self-checking bench for the acceptance and event queue register bank
`timescale 1ns/10ps
module testbench;
	logic sys_clk; // Clock
	logic sys_rst; // Reset
	logic host_rd, host_wr, host_io; // Host strobes
	logic [11:0] host_addr; // Offset
	logic [15:0] host_wdata, host_rdata_ff; // Data
	logic host_rvalid_ff, irq_ff; // Answers
	logic [8:0] cls; // {dma,dribble,hash,group,own,all,bad,under,over}
	logic rx_frame_done; // Frame end
	logic [9:0] tx_event_set, buf_event_set; // Event pulses
	logic miss_inc, col_inc; // Counter pulses
	logic rx_to_buffer_ff, rx_to_dma_ff, rx_len_zero_ff; // Frame verdicts
	logic [2:0] fo; // Captured verdicts {buffer,dma,zero}
	logic [15:0] q [$]; // Drained queue words
	int n_mismatch, tests_run; // Counters
	rxq_regs i_rxq_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .host_rd(host_rd),
		.host_wr(host_wr), .host_io(host_io), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata_ff(host_rdata_ff),
		.host_rvalid_ff(host_rvalid_ff), .rx_frame_done(rx_frame_done),
		.rx_oversize(cls[0]), .rx_undersize(cls[1]), .rx_bad_check(cls[2]),
		.rx_dest_all(cls[3]), .rx_dest_own(cls[4]), .rx_dest_group(cls[5]),
		.rx_dest_hash(cls[6]), .rx_dribble(cls[7]), .rx_dma_sel(cls[8]),
		.tx_event_set(tx_event_set), .buf_event_set(buf_event_set), .miss_inc(miss_inc),
		.col_inc(col_inc), .irq_ff(irq_ff), .rx_to_buffer_ff(rx_to_buffer_ff),
		.rx_to_dma_ff(rx_to_dma_ff), .rx_len_zero_ff(rx_len_zero_ff));
	rxq_host i_rxq_host (.sys_clk(sys_clk), .host_rd(host_rd), .host_wr(host_wr),
		.host_io(host_io), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_rdata_ff(host_rdata_ff), .host_rvalid_ff(host_rvalid_ff));
	// Clock, 10 ns period
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// One comparison
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Read and compare
	task rd(input logic io, input logic [11:0] a, input logic [15:0] exp);
		logic [15:0] w;
		i_rxq_host.reg_read(io, a, w);
		chk(w, exp);
	endtask : rd
	// One received frame, verdicts captured a cycle later
	task frame(input logic [8:0] c);
		@(negedge sys_clk);
		cls = c;
		rx_frame_done = 1'b1;
		@(negedge sys_clk);
		fo = {rx_to_buffer_ff, rx_to_dma_ff, rx_len_zero_ff};
		rx_frame_done = 1'b0;
		cls = ~c;
	endtask : frame
	// Counts and verdict
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog well past the expected run of about 6 us
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		rx_frame_done = 1'b0;
		cls = 9'h000;
		tx_event_set = 10'h000;
		buf_event_set = 10'h000;
		miss_inc = 1'b0;
		col_inc = 1'b0;
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		// Reset state, read-only queue, unmapped places
		rd(1'b0, 12'h120, 16'h0000);
		rd(1'b1, 12'h008, 16'h0000);
		i_rxq_host.reg_write(1'b0, 12'h120, 16'hffc0);
		i_rxq_host.reg_write(1'b1, 12'h008, 16'hffc0);
		rd(1'b0, 12'h120, 16'h0000);
		rd(1'b0, 12'h100, 16'h0000);
		rd(1'b1, 12'h120, 16'h0000);
		$display("test reset_and_map done");
		// All nine acceptance bits, wrong number ignored
		i_rxq_host.reg_write(1'b0, 12'h104, 16'h7fc5);
		rd(1'b0, 12'h104, 16'h7fc5);
		i_rxq_host.reg_write(1'b0, 12'h104, 16'h0d04);
		rd(1'b0, 12'h104, 16'h7fc5);
		i_rxq_host.reg_write(1'b0, 12'h104, 16'h0d05);
		rd(1'b0, 12'h104, 16'h0d05);
		i_rxq_host.reg_write(1'b0, 12'h102, 16'h4103);
		i_rxq_host.reg_write(1'b0, 12'h116, 16'h8017);
		$display("test accept_bits done");
		// Oversize enabled but not kept: interrupt, discard, length zero
		frame(9'h009);
		chk({13'h0000, fo}, 16'h0001);
		@(negedge sys_clk);
		chk({15'h0000, irq_ff}, 16'h0001);
		rd(1'b0, 12'h120, 16'h4804);
		repeat (2) @(negedge sys_clk);
		chk({15'h0000, irq_ff}, 16'h0000);
		rd(1'b0, 12'h120, 16'h0000);
		$display("test oversize_discard done");
		// Kept good frames, DMA then buffer, one idle cycle apart
		frame(9'h110);
		chk({13'h0000, fo}, 16'h0002);
		frame(9'h010);
		chk({13'h0000, fo}, 16'h0004);
		rd(1'b0, 12'h120, 16'h0504);
		rd(1'b0, 12'h120, 16'h0000);
		// Address filter rejects an unlisted destination
		frame(9'h020);
		chk({14'h0000, fo[2:1]}, 16'h0000);
		rd(1'b0, 12'h124, 16'h0104);
		// Promiscuous keep lets the same destination through
		i_rxq_host.reg_write(1'b0, 12'h104, 16'h0d85);
		frame(9'h020);
		chk({13'h0000, fo}, 16'h0004);
		rd(1'b0, 12'h124, 16'h0104);
		$display("test kept_frames done");
		// Event without enable: bits set, no interrupt, clear on read
		frame(9'h00c);
		repeat (2) @(negedge sys_clk);
		chk({15'h0000, irq_ff}, 16'h0000);
		rd(1'b0, 12'h120, 16'h0000);
		rd(1'b0, 12'h124, 16'h1804);
		rd(1'b0, 12'h124, 16'h0004);
		$display("test silent_event done");
		// Four sources pending, drained in priority order over I/O
		i_rxq_host.reg_write(1'b0, 12'h106, 16'h0207);
		i_rxq_host.reg_write(1'b0, 12'h10a, 16'h314b);
		@(negedge sys_clk);
		tx_event_set = 10'h008;
		buf_event_set = 10'h004;
		miss_inc = 1'b1;
		col_inc = 1'b1;
		@(negedge sys_clk);
		tx_event_set = 10'h000;
		buf_event_set = 10'h000;
		repeat (511) @(negedge sys_clk);
		miss_inc = 1'b0;
		col_inc = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk({15'h0000, irq_ff}, 16'h0001);
		i_rxq_host.drain(1'b1, q);
		chk(16'(q.size()), 16'h0005);
		if (q.size() == 5) begin
			chk(q[0], 16'h0208);
			chk(q[1], 16'h014c);
			chk({10'h000, q[2][5:0]}, 16'h0010);
			chk({10'h000, q[3][5:0]}, 16'h0012);
			chk(q[4], 16'h0000);
		end
		repeat (2) @(negedge sys_clk);
		chk({15'h0000, irq_ff}, 16'h0000);
		rd(1'b0, 12'h128, 16'h0008);
		chk(16'(i_rxq_host.n_bad_valid), 16'h0000);
		$display("test queue_priority done");
		tally_and_finish();
	end
endmodule : testbench
